// >>> src/rtp_top.sv
// Notes on behaviour
// - Enabled alarms without square wave drive pin
// - Alarm output keeps working on backup supply
// - Single alarm: pin is flag or inverse
// - Both alarms, polarity one: OR of flags
// - Both alarms, polarity zero: inverted AND
// - All modes off: pin follows output bit
// - No general output level on backup supply
// - Fine mode trims once every minute
// - Direction bit seven: add or remove
// - Two cycles per step, 254 maximum
// - Zero trim amount disables trimming
// - Coarse mode trims 128 times per second
// - Fine step about 1.017 ppm, 127 maximum
// - Trimming continues on backup supply
// - Square wave beats both alarm enables
// - Weekday register write clears match flag
// - Coarse plus square wave gives 64 Hz
`timescale 1ns/1ps
`default_nettype none
module rtp_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic osc_in,
  input wire logic backup_in,
  input wire logic alarm0_hit,
  input wire logic alarm1_hit,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic second_tick,
  input wire logic multi_function_pin_in,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe
);
  // ***********************************************
  // Synchronisers for oscillator and supply status
  // ***********************************************
  logic [1:0] async_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic osc_d_reg;
  assign async_in = {backup_in, osc_in};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  logic osc_s;
  logic on_backup;
  logic osc_rise;
  assign osc_s = sync2_reg[0];
  assign on_backup = sync2_reg[1];
  assign osc_rise = osc_s & ~osc_d_reg;
  // ***********************************************
  // Registers
  // ***********************************************
  logic [7:0] control_reg, control_next;
  logic [7:0] trim_reg, trim_next;
  logic [7:0] wk0_reg, wk0_next;
  logic [7:0] wk1_reg, wk1_next;
  logic pol_reg, pol_next;
  logic flag0_reg, flag0_next;
  logic flag1_reg, flag1_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_wk0;
  logic wr_wk1;
  assign wr_wk0 = reg_wr_en && reg_addr == rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE;
  assign wr_wk1 = reg_wr_en && reg_addr == rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE;
  always_comb begin
    control_next = control_reg;
    trim_next = trim_reg;
    wk0_next = wk0_reg;
    wk1_next = wk1_reg;
    pol_next = pol_reg;
    rdata_next = rdata_reg;
    if (reg_wr_en && reg_addr == rtp_pkg::ADDR_CONTROL) begin
      control_next = reg_wdata;
    end
    if (reg_wr_en && reg_addr == rtp_pkg::ADDR_TRIM) begin
      trim_next = reg_wdata;
    end
    // Polarity is one bit shared by both weekday registers
    if (wr_wk0) begin
      wk0_next = reg_wdata;
      pol_next = reg_wdata[rtp_pkg::WK_POL];
    end
    if (wr_wk1) begin
      wk1_next = reg_wdata;
      pol_next = reg_wdata[rtp_pkg::WK_POL];
    end
    // Match flags: a write clears, a hit in the same cycle wins
    flag0_next = alarm0_hit | (flag0_reg & ~wr_wk0);
    flag1_next = alarm1_hit | (flag1_reg & ~wr_wk1);
    if (reg_rd_en) begin
      unique case (reg_addr)
        rtp_pkg::ADDR_CONTROL: rdata_next = control_reg;
        rtp_pkg::ADDR_TRIM: rdata_next = trim_reg;
        rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE: rdata_next = {pol_reg, wk0_reg[6:4],
          flag0_reg, wk0_reg[2:0]};
        rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE: rdata_next = {pol_reg, wk1_reg[6:4],
          flag1_reg, wk1_reg[2:0]};
        default: rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_reg <= rtp_pkg::CONTROL_RESET;
      trim_reg <= rtp_pkg::TRIM_RESET;
      wk0_reg <= rtp_pkg::WEEKDAY_VALUE_RESET;
      wk1_reg <= rtp_pkg::WEEKDAY_VALUE_RESET;
      pol_reg <= 1'b0;
      flag0_reg <= 1'b0;
      flag1_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      control_reg <= control_next;
      trim_reg <= trim_next;
      wk0_reg <= wk0_next;
      wk1_reg <= wk1_next;
      pol_reg <= pol_next;
      flag0_reg <= flag0_next;
      flag1_reg <= flag1_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
  // ***********************************************
  // Trimmed timebase
  // ***********************************************
  // Supply state is not consulted here, so trimming runs on backup
  logic [rtp_pkg::PRESC_W-1:0] presc_reg, presc_next;
  logic [5:0] sec_reg, sec_next;
  logic [7:0] pend_reg, pend_next;
  logic dir_reg, dir_next;
  logic tick_reg, tick_next;
  logic [1:0] inc;
  logic [15:0] sum;
  logic [8:0] sum8;
  logic sec_wrap;
  logic trim_event;
  logic coarse;
  assign coarse = control_reg[rtp_pkg::CTL_COARSE];
  always_comb begin
    // Add: step by two; remove: hold; one cycle per pending count
    if (pend_reg == 8'h00) begin
      inc = 2'h1;
    end else if (dir_reg) begin
      inc = 2'h2;
    end else begin
      inc = 2'h0;
    end
    sum = {1'b0, presc_reg} + {14'h0000, inc};
    sum8 = {1'b0, presc_reg[rtp_pkg::COARSE_BIT:0]} + {7'h00, inc};
    sec_wrap = osc_rise & sum[rtp_pkg::PRESC_W];
    trim_event = osc_rise & (coarse ? sum8[8]
      : sec_wrap && sec_reg == rtp_pkg::LAST_SECOND);
    presc_next = presc_reg;
    sec_next = sec_reg;
    pend_next = pend_reg;
    dir_next = dir_reg;
    tick_next = sec_wrap;
    if (osc_rise) begin
      presc_next = sum[rtp_pkg::PRESC_W-1:0];
      if (pend_reg != 8'h00) begin
        pend_next = pend_reg - 8'h01;
      end
    end
    if (sec_wrap) begin
      sec_next = (sec_reg == rtp_pkg::LAST_SECOND) ? 6'h00
        : sec_reg + 6'h01;
    end
    // Each step is two cycles; zero amount loads nothing
    if (trim_event) begin
      pend_next = {trim_reg[6:0], 1'b0};
      dir_next = trim_reg[rtp_pkg::TRIM_DIR];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_reg <= '0;
      sec_reg <= 6'h00;
      pend_reg <= 8'h00;
      dir_reg <= 1'b0;
      tick_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      sec_reg <= sec_next;
      pend_reg <= pend_next;
      dir_reg <= dir_next;
      tick_reg <= tick_next;
      osc_d_reg <= osc_s;
    end
  end
  assign second_tick = tick_reg;
  // ***********************************************
  // Pin mode selection
  // ***********************************************
  logic level_reg, level_next;
  logic sqw_en;
  logic a0_en;
  logic a1_en;
  logic sqw_src;
  assign sqw_en = control_reg[rtp_pkg::CTL_SQUARE_WAVE_ENABLE];
  assign a0_en = control_reg[rtp_pkg::CTL_ALARM0_ENABLE];
  assign a1_en = control_reg[rtp_pkg::CTL_ALARM1_ENABLE];
  always_comb begin
    // The full-rate selection bypasses the trimmed prescaler
    unique case (control_reg[rtp_pkg::CTL_FS_HI:rtp_pkg::CTL_FS_LO])
      rtp_pkg::FS_1HZ: sqw_src = presc_reg[rtp_pkg::SQW_1HZ_BIT];
      rtp_pkg::FS_4K: sqw_src = presc_reg[rtp_pkg::SQW_4K_BIT];
      rtp_pkg::FS_8K: sqw_src = presc_reg[rtp_pkg::SQW_8K_BIT];
      rtp_pkg::FS_32K: sqw_src = osc_s;
    endcase
    if (coarse) begin
      sqw_src = presc_reg[rtp_pkg::SQW_64HZ_BIT];
    end
    if (sqw_en) begin
      level_next = on_backup | sqw_src;
    end else if (a0_en & a1_en) begin
      level_next = pol_reg ? (flag0_reg | flag1_reg)
        : ~(flag0_reg & flag1_reg);
    end else if (a0_en) begin
      level_next = pol_reg ? flag0_reg : ~flag0_reg;
    end else if (a1_en) begin
      level_next = pol_reg ? flag1_reg : ~flag1_reg;
    end else begin
      // Released on backup so the pull-up only sees idle high
      level_next = on_backup | control_reg[rtp_pkg::CTL_OUT];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= 1'b1;
    end else begin
      level_reg <= level_next;
    end
  end
  assign multi_function_pin_out = 1'b0;
  assign multi_function_pin_oe = ~level_reg;
  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic gpo_mode;
  assign gpo_mode = ~sqw_en & ~a0_en & ~a1_en;
  property p_gpo;
    gpo_mode && !on_backup |=>
      multi_function_pin_oe == !$past(control_reg[rtp_pkg::CTL_OUT]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("gpo level wrong");
  property p_gpo_backup;
    gpo_mode && on_backup |=> !multi_function_pin_oe;
  endproperty
  a_gpo_backup: assert property (p_gpo_backup)
    else $error("gpo driven on backup");
  property p_single;
    !sqw_en && a0_en && !a1_en |=>
      !multi_function_pin_oe == $past(pol_reg ? flag0_reg : !flag0_reg);
  endproperty
  a_single: assert property (p_single) else $error("single alarm");
  property p_dual_or;
    !sqw_en && a0_en && a1_en && pol_reg |=>
      multi_function_pin_oe == !$past(flag0_reg | flag1_reg);
  endproperty
  a_dual_or: assert property (p_dual_or) else $error("dual or");
  property p_dual_nand;
    !sqw_en && a0_en && a1_en && !pol_reg |=>
      multi_function_pin_oe == $past(flag0_reg & flag1_reg);
  endproperty
  a_dual_nand: assert property (p_dual_nand) else $error("dual nand");
  property p_alarm_backup;
    !sqw_en && a1_en && !a0_en && !pol_reg && flag1_reg && on_backup
      |=> multi_function_pin_oe;
  endproperty
  a_alarm_backup: assert property (p_alarm_backup)
    else $error("alarm lost on backup");
  property p_clear;
    wr_wk0 && !alarm0_hit ##1 !alarm0_hit[*2] |-> !flag0_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_trim_load;
    trim_event |=> pend_reg == {$past(trim_reg[6:0]), 1'b0};
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim load");
  property p_trim_zero;
    trim_event && trim_reg[6:0] == 7'h00 |=> pend_reg == 8'h00;
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("zero trim");
  property p_remove;
    osc_rise && pend_reg != 8'h00 && !dir_reg |=>
      presc_reg == $past(presc_reg);
  endproperty
  a_remove: assert property (p_remove) else $error("remove cycle");
  property p_add;
    osc_rise && pend_reg != 8'h00 && dir_reg |=>
      presc_reg == $past(presc_reg) + 15'h0002;
  endproperty
  a_add: assert property (p_add) else $error("add cycle");
  property p_sqw_prio;
    sqw_en && on_backup |=> !multi_function_pin_oe;
  endproperty
  a_sqw_prio: assert property (p_sqw_prio) else $error("sqw prio");
  c_trim: cover property (trim_event && trim_reg[6:0] != 7'h00);
  c_dual: cover property (a0_en && a1_en && flag0_reg && flag1_reg);
  c_coarse: cover property (sqw_en && coarse && osc_rise);
  c_race: cover property (wr_wk1 && alarm1_hit);
endmodule : rtp_top
`default_nettype wire

// >>> src/rtp_pkg.sv
package rtp_pkg;
  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h07;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_ALM0_WEEKDAY_VALUE = 8'h0D;
  localparam logic [7:0] ADDR_ALM1_WEEKDAY_VALUE = 8'h14;
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] WEEKDAY_VALUE_RESET = 8'h00;
  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int CTL_OUT = 7;
  localparam int CTL_SQUARE_WAVE_ENABLE = 6;
  localparam int CTL_ALARM1_ENABLE = 5;
  localparam int CTL_ALARM0_ENABLE = 4;
  localparam int CTL_COARSE = 2;
  localparam int CTL_FS_HI = 1;
  localparam int CTL_FS_LO = 0;
  localparam int TRIM_DIR = 7;
  localparam int WK_POL = 7;
  localparam int WK_FLAG = 3;
  // ***********************************************
  // Timebase
  // ***********************************************
  localparam int PRESC_W = 15;
  localparam int COARSE_BIT = 7;
  localparam int SQW_64HZ_BIT = 8;
  localparam int SQW_1HZ_BIT = 14;
  localparam int SQW_4K_BIT = 2;
  localparam int SQW_8K_BIT = 1;
  localparam logic [5:0] LAST_SECOND = 6'h3B;
  localparam logic [1:0] FS_1HZ = 2'h0;
  localparam logic [1:0] FS_4K = 2'h1;
  localparam logic [1:0] FS_8K = 2'h2;
  localparam logic [1:0] FS_32K = 2'h3;
endpackage : rtp_pkg

// >>> verification/rtp_pin_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side of the pin: pull-up and host input
// ****************************************
module rtp_pin_host (
  input wire logic drv_out,
  input wire logic drv_oe,
  output logic pin_level
);
  // Released line rises through the pull-up, never holds a stale value
  assign pin_level = drv_oe ? drv_out : 1'b1;
endmodule : rtp_pin_host
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // Stimulus and model state
  // ****************************************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic osc_in = 1'b0;
  logic backup_in = 1'b0;
  logic alarm0_hit = 1'b0;
  logic alarm1_hit = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_out;
  logic pin_oe;
  logic pin_level;
  logic [1:0] osc_div = 2'h0;
  logic dir;
  int osc_edges = 0;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h41E61ACB;
  int amt;
  int e0;
  int e1;
  int e2;
  int e3;
  logic sec_tick;
  int ticks = 0;

  always #12.5 ref_clk = ~ref_clk;

  // Fast oscillator so trimmed 64 Hz half periods fit the run
  always @(posedge ref_clk) begin
    osc_div <= osc_div + 2'h1;
    osc_in <= osc_div[1];
    if (osc_div == 2'h1) osc_edges <= osc_edges + 1;
  end

  always @(posedge ref_clk) begin
    if (sec_tick === 1'b1) ticks <= ticks + 1;
  end

  rtp_top dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .osc_in(osc_in),
    .backup_in(backup_in),
    .alarm0_hit(alarm0_hit),
    .alarm1_hit(alarm1_hit),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .second_tick(sec_tick),
    .multi_function_pin_in(pin_level),
    .multi_function_pin_out(pin_out),
    .multi_function_pin_oe(pin_oe)
  );

  rtp_pin_host host (
    .drv_out(pin_out),
    .drv_oe(pin_oe),
    .pin_level(pin_level)
  );

  // ****************************************
  // Model, drivers and comparisons
  // ****************************************
  function automatic logic exp_pin(int en, int p, logic a, logic b);
    case (en)
      1: return p ? a : ~a;
      2: return p ? b : ~b;
      default: return p ? (a | b) : ~(a & b);
    endcase
  endfunction : exp_pin

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  // Settling covers the register stage plus the two-flop backup sync
  task automatic chkp(logic exp);
    repeat (4) @(posedge ref_clk);
    #1;
    check_count++;
    if (pin_level !== exp) begin
      mismatches++;
      $display("mismatch at %0t: pin %b, expected %b", $time, pin_level, exp);
    end
  endtask : chkp

  task automatic chkn(int got, int exp);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask : rd_chk

  task automatic set_bk(logic b);
    @(posedge ref_clk);
    backup_in <= b;
  endtask : set_bk

  task automatic wait_edge(output int e);
    logic last;
    last = pin_level;
    e = -1;
    for (int i = 0; i < 5000 && e < 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (pin_level !== last) e = osc_edges;
    end
    if (e < 0) begin
      mismatches++;
      $display("mismatch at %0t: pin never toggled", $time);
      tally_and_finish();
    end
  endtask : wait_edge

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(rtp_pkg::ADDR_CONTROL, rtp_pkg::CONTROL_RESET);
    rd_chk(rtp_pkg::ADDR_TRIM, rtp_pkg::TRIM_RESET);
    rd_chk(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, rtp_pkg::WEEKDAY_VALUE_RESET);
    wr(8'h09, 8'h5A);
    rd_chk(8'h09, 8'h00);
    for (int k = 0; k < 4; k++) begin
      set_bk(k[1]);
      wr(rtp_pkg::ADDR_CONTROL, {k[0], 7'h00});
      chkp(k[0] | k[1]);
    end
    for (int p = 0; p < 2; p++) begin
      for (int en = 1; en < 4; en++) begin
        for (int f = 0; f < 4; f++) begin
          set_bk(1'($random(seed)));
          wr(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, {p[0], 7'h00});
          wr(rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE, {p[0], 7'h00});
          wr(rtp_pkg::ADDR_CONTROL, {2'h0, en[1:0], 4'h0});
          @(posedge ref_clk);
          alarm0_hit <= f[0];
          alarm1_hit <= f[1];
          @(posedge ref_clk);
          alarm0_hit <= 1'b0;
          alarm1_hit <= 1'b0;
          chkp(exp_pin(en, p, f[0], f[1]));
        end
      end
    end
    rd_chk(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, 8'h88);
    wr(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, 8'h08);
    rd_chk(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, 8'h00);
    rd_chk(rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE, 8'h08);
    // Hit in the same cycle as the clearing write must win
    @(posedge ref_clk);
    reg_addr <= rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE;
    reg_wdata <= 8'h80;
    reg_wr_en <= 1'b1;
    alarm1_hit <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    alarm1_hit <= 1'b0;
    rd_chk(rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE, 8'h88);
    set_bk(1'b0);
    // Square wave with both alarms on; first toggle is the mode change
    for (int fs = 1; fs < 4; fs++) begin
      wr(rtp_pkg::ADDR_CONTROL, {6'h1C, fs[1:0]});
      wait_edge(e0);
      wait_edge(e1);
      wait_edge(e2);
      wait_edge(e3);
      chkn(e3 - e1, (fs == 1) ? 8 : (fs == 2) ? 4 : 1);
    end
    wr(rtp_pkg::ADDR_CONTROL, 8'h74);
    for (int t = 0; t < 4; t++) begin
      // Zero trim first, as a calibrating host does
      amt = (t == 0) ? 0 : (t == 3) ? 127 : 1 + (($random(seed) & 63) % 60);
      dir = (t == 2); // Sign from error direction
      wr(rtp_pkg::ADDR_TRIM, {dir, amt[6:0]});
      rd_chk(rtp_pkg::ADDR_TRIM, {dir, amt[6:0]});
      wait_edge(e0);
      wait_edge(e1);
      wait_edge(e2);
      chkn(e2 - e1, dir ? 256 - 2 * amt : 256 + 2 * amt);
    end
    wr(rtp_pkg::ADDR_ALM0_WEEKDAY_VALUE, 8'h80);
    wr(rtp_pkg::ADDR_ALM1_WEEKDAY_VALUE, 8'h80);
    set_bk(1'b1);
    chkp(1'b1);
    // Run ends long before one trimmed second could elapse
    chkn(ticks, 0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
